/* File: dual_sar_cfg.svh */
// Constants for the dual converter readout logic.
// Assumes a 100 MHz system clock; included by the package and the modules.
`ifndef DUAL_SAR_CFG_SVH
`define DUAL_SAR_CFG_SVH

`define CODE_W          16
`define RAW_W           18
`define NEG_FS_CODE     16'h8000
`define POS_FS_CODE     16'h7FFF
`define MID_CODE        16'h0000
`define CLK_PERIOD_NS   10
`define T_CONV_NS       422
`define CONV_CYCLES     (`T_CONV_NS / `CLK_PERIOD_NS)
`define CONV_CNT_W      6
`define CONV_CNT_RST    6'h00
`define SHIFT_RST       16'h0000

`endif

/* File: dual_sar_pkg.sv */
// Types and the code saturation function shared by the converter and readout.
// Assumes dual_sar_cfg.svh is on the include path.
`include "dual_sar_cfg.svh"

package dual_sar_pkg;

	typedef logic [`CODE_W-1:0]        code_t;
	typedef logic signed [`RAW_W-1:0]  raw_t;
	typedef logic [`CONV_CNT_W-1:0]    conv_cnt_t;

	typedef enum logic
	{
		ST_ACQ = 1'b0,
		ST_CNV = 1'b1
	} conv_state_t;

	// Clamp a wide signed sample into the two's complement code range
	function automatic code_t saturate_code(input raw_t raw);
		code_t res;
		res = raw[`CODE_W-1:0];
		if (raw > $signed({2'b00, `POS_FS_CODE}))
		begin
			res = `POS_FS_CODE;
		end
		else if (raw < $signed({2'b11, `NEG_FS_CODE}))
		begin
			res = `NEG_FS_CODE;
		end
		return res;
	endfunction

endpackage

/* File: sar_converter.sv */
// One successive-approximation converter timed by the system clock.
// Assumes start_i is a one-cycle pulse on clk_sys_i, spaced by the host.
`timescale 1ns/10ps
`include "dual_sar_cfg.svh"

module sar_converter
(
	input  wire logic               clk_sys_i,   // System clock
	input  wire logic               rst_n_i,     // Synchronous reset, active low
	input  wire logic               start_i,     // Conversion start pulse
	input  wire dual_sar_pkg::raw_t sample_i,    // Quantized input at this instant
	output logic                    busy_o,      // Converting, inputs isolated
	output logic                    acquiring_o, // Sampling stage connected
	output logic                    done_o,      // Conversion done strobe
	output dual_sar_pkg::code_t     result_o     // Latest result
);
	import dual_sar_pkg::*;

	// Done is registered one edge after the timer empties
	localparam int CONV_LIM = `CONV_CYCLES + 1;

	conv_state_t state_q;
	conv_cnt_t   cnt_q;
	raw_t        held_q;
	logic        done_q;
	code_t       result_q;

	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_n_i)
		begin
			state_q <= ST_ACQ;
		end
		else
		begin
			case (state_q)
				ST_ACQ:
				begin
					if (start_i)
					begin
						state_q <= ST_CNV;
					end
				end
				ST_CNV:
				begin
					if (cnt_q == `CONV_CNT_RST)
					begin
						state_q <= ST_ACQ;
					end
				end
				default:
				begin
					state_q <= ST_ACQ;
				end
			endcase
		end
	end

	// Internal conversion timer, free of the serial clock
	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_n_i)
		begin
			cnt_q <= `CONV_CNT_RST;
		end
		else if (state_q == ST_ACQ && start_i)
		begin
			cnt_q <= conv_cnt_t'(`CONV_CYCLES - 1);
		end
		else if (state_q == ST_CNV && cnt_q != `CONV_CNT_RST)
		begin
			cnt_q <= cnt_q - 6'h01;
		end
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_n_i)
		begin
			held_q <= '0;
		end
		else if (state_q == ST_ACQ && start_i)
		begin
			held_q <= sample_i;
		end
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_n_i)
		begin
			done_q   <= 1'b0;
			result_q <= `MID_CODE;
		end
		else
		begin
			done_q <= (state_q == ST_CNV) && (cnt_q == `CONV_CNT_RST);
			if (state_q == ST_CNV && cnt_q == `CONV_CNT_RST)
			begin
				result_q <= saturate_code(held_q);
			end
		end
	end

	assign busy_o      = (state_q == ST_CNV);
	assign acquiring_o = (state_q == ST_ACQ);
	assign done_o      = done_q;
	assign result_o    = result_q;

	chk_conv_time_bound: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(state_q == ST_ACQ && start_i) |-> ##[1:CONV_LIM] done_q)
		else $error("conversion did not finish in time");

	chk_done_single_pulse: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		done_q |=> !done_q && state_q == ST_ACQ)
		else $error("done strobe wider than one cycle or not in acquisition");

	chk_sat_positive: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(state_q == ST_CNV && cnt_q == `CONV_CNT_RST && held_q > $signed(18'sh07FFF))
		|=> result_q == `POS_FS_CODE)
		else $error("positive overrange not saturated");

	chk_sat_negative: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(state_q == ST_CNV && cnt_q == `CONV_CNT_RST && held_q < $signed(18'sh38000))
		|=> result_q == `NEG_FS_CODE)
		else $error("negative overrange not saturated");

	chk_inputs_isolated: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(state_q == ST_CNV) |=> $stable(held_q))
		else $error("sample changed during conversion");

endmodule

/* File: dual_sar_readout.sv */
// Dual simultaneous-sampling converter control and two-line serial readout.
// Assumes chip select and serial clock arrive asynchronously from a host.
`timescale 1ns/10ps
`include "dual_sar_cfg.svh"

// Function
// - Two 16-bit converters sample the same instant
// - Chip select rising starts both conversions
// - Conversion internally timed, done within 422 ns
// - Inputs isolated converting, then back to acquisition
// - Converter returns done strobe and result
// - Two's complement codes, saturate at 8000/7FFF
// - Chip select falling drives valid first bits
// - Each serial clock launch edge advances outputs
// - Chip select rising releases outputs to high-impedance
// - MSB upper line, next lower, then zeros
// - Chip select high time selects latency zero/one
// - Acquisition after reset and every done strobe
module dual_sar_readout
(
	input  wire logic               clk_sys_i,                  // System clock
	input  wire logic               rst_n_i,                    // Synchronous reset, active low
	input  wire logic               cs_n_i,                     // Chip select pin, active low
	input  wire logic               sclk_i,                     // Serial clock pin
	input  wire dual_sar_pkg::raw_t analog_code_a_i,            // Channel A quantized input
	input  wire dual_sar_pkg::raw_t analog_code_b_i,            // Channel B quantized input
	output logic                    upper_serial_out_line_a_o,  // Channel A upper data line
	output logic                    upper_serial_out_line_a_oe_o, // Drive enable
	output logic                    lower_serial_out_line_a_o,  // Channel A lower data line
	output logic                    lower_serial_out_line_a_oe_o, // Drive enable
	output logic                    upper_serial_out_line_b_o,  // Channel B upper data line
	output logic                    upper_serial_out_line_b_oe_o, // Drive enable
	output logic                    lower_serial_out_line_b_o,  // Channel B lower data line
	output logic                    lower_serial_out_line_b_oe_o, // Drive enable
	output logic                    conversion_done_strobe_a_o, // Channel A done pulse
	output logic                    conversion_done_strobe_b_o, // Channel B done pulse
	output logic                    acquiring_a_o,              // Channel A sampling
	output logic                    acquiring_b_o               // Channel B sampling
);
	import dual_sar_pkg::*;

	logic  cs_meta_q;
	logic  cs_sync_q;
	logic  cs_prev_q;
	logic  sclk_meta_q;
	logic  sclk_sync_q;
	logic  sclk_prev_q;
	logic  cs_rise;
	logic  cs_fall;
	logic  sclk_rise;
	logic  frame_q;
	code_t shift_a_q;
	code_t shift_b_q;
	code_t shift_a_d;
	code_t shift_b_d;
	code_t result_a;
	code_t result_b;
	logic  busy_a;
	logic  busy_b;

	// Two-stage synchronisers for the host pins
	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_n_i)
		begin
			cs_meta_q <= 1'b1;
			cs_sync_q <= 1'b1;
			cs_prev_q <= 1'b1;
		end
		else
		begin
			cs_meta_q <= cs_n_i;
			cs_sync_q <= cs_meta_q;
			cs_prev_q <= cs_sync_q;
		end
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_n_i)
		begin
			sclk_meta_q <= 1'b0;
			sclk_sync_q <= 1'b0;
			sclk_prev_q <= 1'b0;
		end
		else
		begin
			sclk_meta_q <= sclk_i;
			sclk_sync_q <= sclk_meta_q;
			sclk_prev_q <= sclk_sync_q;
		end
	end

	assign cs_rise   = cs_sync_q && !cs_prev_q;
	assign cs_fall   = !cs_sync_q && cs_prev_q;
	assign sclk_rise = sclk_sync_q && !sclk_prev_q;

	// Both converters share the one start pulse
	sar_converter u_conv_a
	(
		.clk_sys_i   (clk_sys_i),
		.rst_n_i     (rst_n_i),
		.start_i     (cs_rise),
		.sample_i    (analog_code_a_i),
		.busy_o      (busy_a),
		.acquiring_o (acquiring_a_o),
		.done_o      (conversion_done_strobe_a_o),
		.result_o    (result_a)
	);

	sar_converter u_conv_b
	(
		.clk_sys_i   (clk_sys_i),
		.rst_n_i     (rst_n_i),
		.start_i     (cs_rise),
		.sample_i    (analog_code_b_i),
		.busy_o      (busy_b),
		.acquiring_o (acquiring_b_o),
		.done_o      (conversion_done_strobe_b_o),
		.result_o    (result_b)
	);

	// Frame open from chip select falling to rising
	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_n_i)
		begin
			frame_q <= 1'b0;
		end
		else if (cs_rise)
		begin
			frame_q <= 1'b0;
		end
		else if (cs_fall)
		begin
			frame_q <= 1'b1;
		end
	end

	// Load at frame start takes whichever result is finished by then
	always_comb
	begin
		shift_a_d = shift_a_q;
		shift_b_d = shift_b_q;
		if (cs_fall)
		begin
			shift_a_d = result_a;
			shift_b_d = result_b;
		end
		else if (frame_q && sclk_rise)
		begin
			shift_a_d = {shift_a_q[`CODE_W-3:0], 2'b00};
			shift_b_d = {shift_b_q[`CODE_W-3:0], 2'b00};
		end
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_n_i)
		begin
			shift_a_q <= `SHIFT_RST;
			shift_b_q <= `SHIFT_RST;
		end
		else
		begin
			shift_a_q <= shift_a_d;
			shift_b_q <= shift_b_d;
		end
	end

	// Upper line carries the odd-numbered bit of each pair
	assign upper_serial_out_line_a_o    = shift_a_q[`CODE_W-1];
	assign lower_serial_out_line_a_o    = shift_a_q[`CODE_W-2];
	assign upper_serial_out_line_b_o    = shift_b_q[`CODE_W-1];
	assign lower_serial_out_line_b_o    = shift_b_q[`CODE_W-2];
	assign upper_serial_out_line_a_oe_o = frame_q;
	assign lower_serial_out_line_a_oe_o = frame_q;
	assign upper_serial_out_line_b_oe_o = frame_q;
	assign lower_serial_out_line_b_oe_o = frame_q;

	sequence frame_start_s;
		cs_fall;
	endsequence

	sequence first_bits_s;
		frame_q && upper_serial_out_line_a_oe_o && lower_serial_out_line_b_oe_o;
	endsequence

	chk_start_both_conv: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(cs_rise && !busy_a && !busy_b) |=> busy_a && busy_b)
		else $error("conversions did not start together");

	chk_same_instant: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		busy_a == busy_b)
		else $error("converters out of step");

	chk_first_bits: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		frame_start_s |=> first_bits_s
		##0 (upper_serial_out_line_a_o == $past(result_a[15])
		&& lower_serial_out_line_a_o == $past(result_a[14])))
		else $error("first bits not presented at frame start");

	chk_bits_advance: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(frame_q && sclk_rise && !cs_fall && !cs_rise)
		|=> upper_serial_out_line_b_o == $past(shift_b_q[13])
		&& lower_serial_out_line_b_o == $past(shift_b_q[12]))
		else $error("serial data did not advance");

	chk_release_hiz: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		cs_rise |=> !upper_serial_out_line_a_oe_o && !lower_serial_out_line_b_oe_o)
		else $error("outputs still driven after chip select rose");

	chk_zero_fill: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(frame_q && sclk_rise && !cs_fall) |=> shift_a_q[1:0] == 2'b00)
		else $error("zeros not shifted in");

	chk_latency_zero: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(cs_fall && !busy_a) |=> shift_a_q == $past(result_a))
		else $error("frame did not return latest finished result");

	chk_acq_after_done: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		conversion_done_strobe_a_o |-> acquiring_a_o ##1 acquiring_a_o)
		else $error("not in acquisition after done strobe");

	chk_done_pairs: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		conversion_done_strobe_a_o == conversion_done_strobe_b_o)
		else $error("done strobes not paired");

	chk_reconnect: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		$fell(busy_b) |-> acquiring_b_o)
		else $error("sampling stage not reconnected");

endmodule

/* File: host_model.sv */
// Host controller model: reads one frame, then starts a conversion.
// Assumes the bench resolves each data line to z while its enable is low.
`timescale 1ns/10ps

module host_model
(
	input  wire logic       clk_sys_i,  // System clock
	input  wire logic       go_i,       // Request one operation
	input  wire logic [7:0] high_cyc_i, // Chip select high cycles after start
	input  wire logic [3:0] sdo_i,      // A upper, A lower, B upper, B lower
	output logic            cs_n_o,     // Chip select, active low
	output logic            sclk_o,     // Serial clock, still outside frames
	output logic [17:0]     word_a_o,   // Nine captured pairs, channel A
	output logic [17:0]     word_b_o,   // Nine captured pairs, channel B
	output logic            busy_o      // Operation in progress
);
	initial
	begin
		cs_n_o = 1'b1;
		sclk_o = 1'b0;
		busy_o = 1'b0;
		word_a_o = 18'h00000;
		word_b_o = 18'h00000;
		forever
		begin
			@(posedge clk_sys_i);
			if (go_i)
			begin
				busy_o <= 1'b1;
				cs_n_o <= 1'b0;
				repeat (4) @(posedge clk_sys_i);
				for (int p = 0; p < 9; p++)
				begin
					if (p != 0)
					begin
						sclk_o <= 1'b1; // 80 ns period
						repeat (4) @(posedge clk_sys_i);
						sclk_o <= 1'b0;
					end
					word_a_o <= {word_a_o[15:0], sdo_i[3:2]};
					word_b_o <= {word_b_o[15:0], sdo_i[1:0]};
					repeat (4) @(posedge clk_sys_i);
				end
				cs_n_o <= 1'b1; // After last launch
				repeat (high_cyc_i) @(posedge clk_sys_i);
				busy_o <= 1'b0;
			end
		end
	end
endmodule

/* File: dual_sar_readout_tb.sv */
// Self-checking bench for the dual converter readout.
// Assumes host_model drives the link; data lines float when not enabled.
`timescale 1ns/10ps

module dual_sar_readout_tb;
	import dual_sar_pkg::*;
	logic        clk_sys_i;
	logic        rst_n_i;
	logic        go;
	logic        cs_n;
	logic        sclk;
	logic        busy;
	logic [7:0]  high_cyc;
	raw_t        code_a;
	raw_t        code_b;
	logic        ua, uae, la, lae, ub, ube, lb, lbe;
	logic        done_a, done_b, acq_a, acq_b;
	logic [3:0]  sdo;
	logic [17:0] word_a, word_b;
	code_t       reg_a, reg_b, pend_a, pend_b;
	logic        pend_v;
	logic        cs_q;
	int          fail_count, num_checks, cnt, seed_dummy;
	raw_t        q[$];

	assign sdo = {uae ? ua : 1'bz, lae ? la : 1'bz, ube ? ub : 1'bz, lbe ? lb : 1'bz};

	dual_sar_readout i_dual_sar_readout (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
		.cs_n_i(cs_n), .sclk_i(sclk), .analog_code_a_i(code_a), .analog_code_b_i(code_b),
		.upper_serial_out_line_a_o(ua), .upper_serial_out_line_a_oe_o(uae),
		.lower_serial_out_line_a_o(la), .lower_serial_out_line_a_oe_o(lae),
		.upper_serial_out_line_b_o(ub), .upper_serial_out_line_b_oe_o(ube),
		.lower_serial_out_line_b_o(lb), .lower_serial_out_line_b_oe_o(lbe),
		.conversion_done_strobe_a_o(done_a), .conversion_done_strobe_b_o(done_b),
		.acquiring_a_o(acq_a), .acquiring_b_o(acq_b));

	host_model i_host_model (.clk_sys_i(clk_sys_i), .go_i(go), .high_cyc_i(high_cyc),
		.sdo_i(sdo), .cs_n_o(cs_n), .sclk_o(sclk), .word_a_o(word_a), .word_b_o(word_b),
		.busy_o(busy));

	initial
	begin
		clk_sys_i = 1'b0;
		forever #5 clk_sys_i = ~clk_sys_i;
	end

	task automatic test_done;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic check(input logic [17:0] got, input logic [17:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("Error at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask

	function automatic code_t clamp_ref(input int v);
		if (v > 32767)
			return 16'h7FFF;
		if (v < -32768)
			return 16'h8000;
		return v[15:0];
	endfunction

	task automatic wait_busy(input logic lvl);
		int n;
		n = 0;
		while (busy !== lvl && n < 400)
		begin
			@(posedge clk_sys_i);
			n++;
		end
		if (busy !== lvl)
		begin
			fail_count++;
			$display("Error at %0t: busy %0h expected %0h", $time, busy, lvl);
			test_done();
		end
	endtask

	// Frame reads the result register as the model holds it
	task automatic run_op(input raw_t a, input raw_t b, input logic [7:0] h);
		code_a <= a;
		code_b <= b;
		high_cyc <= h;
		go <= 1'b1;
		wait_busy(1'b1);
		go <= 1'b0;
		wait_busy(1'b0);
		check(word_a, {reg_a, 2'b00});
		check(word_b, {reg_b, 2'b00});
		if (pend_v)
		begin
			reg_a = pend_a;
			reg_b = pend_b;
		end
		pend_a = clamp_ref(int'(a));
		pend_b = clamp_ref(int'(b));
		pend_v = (h < 8'h28);
		if (!pend_v)
		begin
			reg_a = pend_a;
			reg_b = pend_b;
		end
	endtask

	// Conversion timing seen from the chip select pin
	always @(posedge clk_sys_i)
	begin
		if (!rst_n_i)
			cnt = 99;
		else
		begin
			if (cs_n === 1'b1 && cs_q === 1'b0)
				cnt = 1;
			else if (cnt < 99)
				cnt++;
			check({17'h0, done_a}, {17'h0, done_b});
			if (done_a === 1'b1)
				check({17'h0, cnt inside {[44:46]}}, 18'h1);
			if (cnt >= 6 && cnt <= 43)
				check({16'h0, acq_a, acq_b}, 18'h0);
			if (cnt >= 48)
				check({16'h0, acq_a, acq_b}, 18'h3);
			if (cnt == 5)
				check({14'h0, uae, lae, ube, lbe}, 18'h0);
		end
		cs_q = cs_n;
	end

	initial
	begin
		rst_n_i = 1'b0;
		go = 1'b0;
		high_cyc = 8'h00;
		code_a = 18'h00000;
		code_b = 18'h00000;
		fail_count = 0;
		num_checks = 0;
		reg_a = 16'h0000;
		reg_b = 16'h0000;
		pend_v = 1'b0;
		cs_q = 1'b1;
		seed_dummy = $urandom(38689);
		q = '{18'h1FFFF, 18'h20000, 18'h00000, 18'h07FFF, 18'h38000, 18'h08000,
			18'h37FFF, 18'h00001};
		repeat (3) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		@(posedge clk_sys_i);
		foreach (q[i])
			run_op(q[i], q[7 - i], (i % 2) ? 8'h03 : 8'h3C);
		// Mid-run reset cuts off the running conversion
		rst_n_i <= 1'b0;
		repeat (3) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		reg_a = 16'h0000;
		reg_b = 16'h0000;
		pend_v = 1'b0;
		@(posedge clk_sys_i);
		for (int i = 0; i < 12; i++)
			run_op(raw_t'(int'($urandom_range(0, 98303)) - 49152),
				raw_t'(int'($urandom_range(0, 98303)) - 49152),
				$urandom_range(0, 1) ? 8'h03 : 8'h3C);
		run_op(18'h00000, 18'h00000, 8'h3C);
		run_op(18'h00000, 18'h00000, 8'h3C);
		test_done();
	end
endmodule
